// file: dv/tnb_mcu_model.sv
`timescale 1ns/1ps
// ----------------------------------------
// Controller side bus master
// ----------------------------------------
module tnb_mcu_model
(
  input  logic        clk,
  output logic [4:0]  awaddr,
  output logic        awvalid,
  input  logic        awready,
  output logic [31:0] wdata,
  output logic        wvalid,
  input  logic        wready,
  input  logic        bvalid,
  output logic        bready,
  output logic [4:0]  araddr,
  output logic        arvalid,
  input  logic        arready,
  input  logic [31:0] rdata,
  input  logic [1:0]  rresp,
  input  logic        rvalid,
  output logic        rready
);
  initial {awaddr, awvalid, wdata, wvalid, bready} = '0;
  initial {araddr, arvalid, rready} = '0;
  // Never touches the reserved slot; threshold kept above 80
  task automatic wr(input logic [4:0] a, input logic [7:0] d);
    int i;
    @(posedge clk);
    awaddr <= a; awvalid <= 1'b1; wdata <= {24'h0, d};
    wvalid <= 1'b1; bready <= 1'b1;
    for (i = 0; i < 50 && !bvalid; i++)
    begin
      @(posedge clk);
      if (awvalid && awready) awvalid <= 1'b0;
      if (wvalid && wready) wvalid <= 1'b0;
    end
    bready <= 1'b0;
    if (i == 50) tnb_regs_tb.end_sim(1);
  endtask
  task automatic rd(input logic [4:0] a, output logic [31:0] d,
                    output logic [1:0] r);
    int i;
    @(posedge clk);
    araddr <= a; arvalid <= 1'b1; rready <= 1'b1;
    for (i = 0; i < 50 && !rvalid; i++)
    begin
      @(posedge clk);
      if (arvalid && arready) arvalid <= 1'b0;
    end
    d = rdata; r = rresp; rready <= 1'b0;
    if (i == 50) tnb_regs_tb.end_sim(1);
  endtask
endmodule

// file: dv/tnb_regs_sva.sv
`timescale 1ns/1ps
// ----------------------------------------
// Port checker
// ----------------------------------------
module tnb_regs_sva
(
  input wire        clk,
  input wire        sys_rst,
  input wire        powerdown_reset_n,
  input wire        noise_detected,
  input wire        enc_trigger,
  input wire        dec_trigger,
  input wire        encoded_bit,
  input wire        burst_detect_on,
  input wire        rx_mute,
  input wire [3:0]  frame_delay,
  input wire        tone_gen_run,
  input wire        decoder_run,
  input wire        enc_init,
  input wire        dec_init,
  input wire        encoded_tx_pin,
  input wire [11:0] tone1_freq,
  input wire        tone1_on
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (sys_rst);
  // Pin release reaches the outputs only after the synchroniser settles
  logic [2:0] quiet_cnt;
  always @(posedge clk)
  begin
    if (sys_rst || !powerdown_reset_n)
      quiet_cnt <= 3'h0;
    else if (quiet_cnt != 3'h7)
      quiet_cnt <= quiet_cnt + 3'h1;
  end
  sequence s_noise;
    noise_detected && burst_detect_on;
  endsequence
  sequence s_pd_low;
    !powerdown_reset_n [*6];
  endsequence
  property p_mute;
    s_noise |=> rx_mute;
  endproperty
  a_mute: assert property (p_mute) else $error("no mute");
  property p_nb_clr;
    s_noise |=> ##1 !burst_detect_on;
  endproperty
  a_nb_clr: assert property (p_nb_clr) else $error("nb on");
  property p_delay;
    frame_delay == 4'h2 || frame_delay == 4'h6;
  endproperty
  a_delay: assert property (p_delay) else $error("delay");
  property p_excl;
    tone_gen_run |-> !decoder_run && !burst_detect_on;
  endproperty
  a_excl: assert property (p_excl) else $error("tone excl");
  property p_enc_init;
    enc_init |-> $past(enc_trigger);
  endproperty
  a_enc_init: assert property (p_enc_init) else $error("enc");
  property p_dec_init;
    dec_init |-> $past(dec_trigger);
  endproperty
  a_dec_init: assert property (p_dec_init) else $error("dec");
  property p_tx;
    quiet_cnt == 3'h7 |-> encoded_tx_pin == $past(encoded_bit);
  endproperty
  a_tx: assert property (p_tx) else $error("tx pin");
  property p_pd;
    s_pd_low |-> tone1_freq == 12'h000 && !tone1_on && !rx_mute;
  endproperty
  a_pd: assert property (p_pd) else $error("pd clr");
endmodule

bind tnb_regs tnb_regs_sva u_tnb_regs_sva (.*);

// file: dv/tnb_regs_tb.sv
`timescale 1ns/1ps
`include "tnb_defs.vh"
module tnb_regs_tb;
  logic clk = 0, sys_rst = 1, pd_n = 1, tread = 0, noise = 0;
  logic etrig = 0, dtrig = 0, ebit = 0, awr, wr_, arr, bv, rv;
  logic [4:0] aw, ar;
  logic [31:0] wd, rdt, d;
  logic [1:0] br, rr, r;
  logic awv, wv, bre, arv, rre;
  logic [11:0] t1f, t1a, t2f, t2a;
  logic [7:0] thr;
  logic [3:0] fd;
  logic [13:0] einp;
  logic nbon, mute, tgr, dcr, t1, t2, ei, di, hpb, etx;
  logic [13:0] adc = 14'h2abc, tsmp = 14'h1234;
  int miscompares = 0, cmp_count = 0, s;
  initial forever #20 clk = ~clk;
  always @(posedge clk) ebit <= ~ebit;
  tnb_mcu_model u_tnb_mcu_model (.clk(clk), .awaddr(aw), .awvalid(awv),
    .awready(awr), .wdata(wd), .wvalid(wv), .wready(wr_), .bvalid(bv),
    .bready(bre), .araddr(ar), .arvalid(arv), .arready(arr), .rdata(rdt),
    .rresp(rr), .rvalid(rv), .rready(rre));
  tnb_regs u_tnb_regs (.clk(clk), .sys_rst(sys_rst),
    .powerdown_reset_n(pd_n), .s_axi_awaddr(aw), .s_axi_awvalid(awv),
    .s_axi_awready(awr), .s_axi_wdata(wd), .s_axi_wstrb(4'hf),
    .s_axi_wvalid(wv), .s_axi_wready(wr_), .s_axi_bresp(br),
    .s_axi_bvalid(bv), .s_axi_bready(bre), .s_axi_araddr(ar),
    .s_axi_arvalid(arv), .s_axi_arready(arr), .s_axi_rdata(rdt),
    .s_axi_rresp(rr), .s_axi_rvalid(rv), .s_axi_rready(rre),
    .dsp_tone_read(tread), .noise_detected(noise), .enc_trigger(etrig),
    .dec_trigger(dtrig), .adc_sample(adc), .tone_sample(tsmp),
    .codec_sample(14'h0000), .encoded_bit(ebit), .tone1_freq(t1f),
    .tone1_atten(t1a), .tone2_freq(t2f), .tone2_atten(t2a),
    .burst_threshold(thr), .burst_detect_on(nbon), .rx_mute(mute),
    .frame_delay(fd), .tone_gen_run(tgr), .decoder_run(dcr),
    .tone1_on(t1), .tone2_on(t2), .enc_init(ei), .dec_init(di),
    .enc_input(einp), .highpass_stage_bypass(hpb), .encoded_tx_pin(etx));
  task automatic end_sim(input bit hang);
    if (hang) miscompares++;
    if (miscompares == 0 && cmp_count > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, exp);
    cmp_count++;
    if (got !== exp)
    begin
      miscompares++;
      $display("BAD %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic rchk(input logic [4:0] a, input logic [31:0] exp);
    u_tnb_mcu_model.rd(a, d, r);
    chk(d, exp);
  endtask
  task automatic wr(input logic [4:0] a, input logic [7:0] v);
    u_tnb_mcu_model.wr(a, v);
    repeat (2) @(posedge clk);
  endtask
  // One-cycle strobe on the noise report or on the engine's tone read
  task automatic pulse(input bit sel_noise);
    @(posedge clk);
    if (sel_noise)
      noise <= 1'b1;
    else
      tread <= 1'b1;
    @(posedge clk) {noise, tread} <= 2'b00;
    @(posedge clk);
  endtask
  initial
  begin
    repeat (8) @(posedge clk);
    sys_rst <= 1'b0;
    repeat (6) @(posedge clk);
    rchk(`TNB_OFF_CTRL, 0);
    u_tnb_mcu_model.rd(5'h08, d, r);
    chk(r, `TNB_RESP_SLVERR);
    wr(`TNB_OFF_MISC, 8'hff);
    rchk(`TNB_OFF_MISC, 32'hf0);
    chk(hpb, 1);
    chk(einp, 14'h2a80);
    wr(`TNB_OFF_CTRL, 8'h1b);
    rchk(`TNB_OFF_CTRL, 32'h0b);
    chk({tgr, dcr, t1, t2, nbon}, 5'b10110);
    chk(einp, 14'h1234);
    wr(`TNB_OFF_TONE_LOW, 8'h34);
    for (s = 0; s < 4; s++)
    begin
      wr(`TNB_OFF_TONE_HIGH, {s[1:0], 2'b00, 4'h9 + s[3:0]});
      rchk(`TNB_OFF_CTRL, 32'h8b);
      pulse(1'b0);
      rchk(`TNB_OFF_CTRL, 32'h0b);
      chk({t2a, t2f, t1a, t1f} >> (s * 12) & 12'hfff,
          {4'h9 + s[3:0], 8'h34});
    end
    wr(`TNB_OFF_CTRL, 8'h60);
    wr(`TNB_OFF_TONE_HIGH, 8'h51);
    chk({fd, nbon, thr}, {4'h6, 1'b1, 8'h51});
    pulse(1'b1);
    rchk(`TNB_OFF_CTRL, 32'ha0);
    chk(mute, 1);
    wr(`TNB_OFF_CTRL, 8'h00);
    chk(fd, 4'h2);
    wr(`TNB_OFF_MISC, 8'hc0);
    rchk(`TNB_OFF_STATUS, 32'h2abc);
    @(posedge clk) {etrig, dtrig} <= 2'b11;
    @(posedge clk) {etrig, dtrig} <= 2'b00;
    @(negedge clk) chk({ei, di}, 2'b11);
    chk(etx, !ebit);
    @(posedge clk) pd_n <= 1'b0;
    repeat (8) @(posedge clk);
    rchk(`TNB_OFF_MISC, 0);
    pd_n <= 1'b1;
    end_sim(0);
  end
  initial
  begin
    repeat (20000) @(posedge clk);
    end_sim(1);
  end
endmodule

// file: inc/tnb_defs.vh
`ifndef TNB_DEFS_VH
`define TNB_DEFS_VH

// Register byte addresses (own map, one aligned word each)
`define TNB_OFF_TONE_LOW    5'h10
`define TNB_OFF_TONE_HIGH   5'h14
`define TNB_OFF_RSVD_SIX    5'h18
`define TNB_OFF_CTRL        5'h1c
`define TNB_OFF_MISC        5'h00
`define TNB_OFF_STATUS      5'h04

// Control register fields
`define TNB_CTL_READY       7
`define TNB_CTL_NB_EN       6
`define TNB_CTL_DELAY6      5
`define TNB_CTL_DONTCARE    4
`define TNB_CTL_TONE_EN     3
`define TNB_CTL_TONE1       1
`define TNB_CTL_TONE2       0
`define TNB_CTL_WMASK       8'h6b

// Misc register fields
`define TNB_MISC_ENC_RST    7
`define TNB_MISC_DEC_RST    6
`define TNB_MISC_LINEAR     5
`define TNB_MISC_HPF_DIS    4
`define TNB_MISC_WMASK      8'hf0

// Tone high register fields
`define TNB_SLOT_MSB        7
`define TNB_SLOT_LSB        6
`define TNB_PAR_HI_MSB      3

// Frame delays
`define TNB_DELAY_LONG      4'h6
`define TNB_DELAY_SHORT     4'h2

`define TNB_RESET_BYTE      8'h00
`define TNB_RESP_OKAY       2'b00
`define TNB_RESP_SLVERR     2'b10

`endif

// file: rtl/tnb_regs.v
// Summary of operation
// - Tone parameter is low register plus low nibble of high register.
// - All registers clear while the power-down reset pin is low.
// - With tone generator on, high register bits 7:6 pick the slot.
// - Tone off and burst enabled: whole high register is the threshold.
// - Ready flag sets on high register write, clears when engine reads.
// - Burst enable with tone off starts detection; cleared on noise.
// - Detected noise mutes the receive path.
// - Control bit 5 selects six or two frame delay.
// - Tone enable runs tone generator instead of decoder, stops detection.
// - Tone enable feeds tone samples to encoder, else ADC samples; result goes to encoded transmit pin.
// - Control bit 1 enables the first tone.
// - Control bit 0 enables the second tone.
// - Control bit 4 has no effect on read or write.
// - Misc: encoder reset, decoder reset, linear mode, filter disable.
// - Encoder reset bit forces encoder init on each trigger.
// - Decoder reset bit forces decoder init on each trigger.
// - With tone off, linear mode acts as 8-bit codec, truncating six low bits.
// - Filter disable bypasses the transmit high-pass stage.
`timescale 1ns/1ps
`include "tnb_defs.vh"

module tnb_regs
(
  input  wire        clk,
  input  wire        sys_rst,
  input  wire        powerdown_reset_n,
  // AXI4-Lite slave
  input  wire [4:0]  s_axi_awaddr,
  input  wire        s_axi_awvalid,
  output wire        s_axi_awready,
  input  wire [31:0] s_axi_wdata,
  input  wire [3:0]  s_axi_wstrb,
  input  wire        s_axi_wvalid,
  output wire        s_axi_wready,
  output reg  [1:0]  s_axi_bresp,
  output reg         s_axi_bvalid,
  input  wire        s_axi_bready,
  input  wire [4:0]  s_axi_araddr,
  input  wire        s_axi_arvalid,
  output wire        s_axi_arready,
  output reg  [31:0] s_axi_rdata,
  output reg  [1:0]  s_axi_rresp,
  output reg         s_axi_rvalid,
  input  wire        s_axi_rready,
  // DSP engine side
  input  wire        dsp_tone_read,
  input  wire        noise_detected,
  input  wire        enc_trigger,
  input  wire        dec_trigger,
  input  wire [13:0] adc_sample,
  input  wire [13:0] tone_sample,
  input  wire [13:0] codec_sample,
  input  wire        encoded_bit,
  output reg  [11:0] tone1_freq,
  output reg  [11:0] tone1_atten,
  output reg  [11:0] tone2_freq,
  output reg  [11:0] tone2_atten,
  output reg  [7:0]  burst_threshold,
  output reg         burst_detect_on,
  output reg         rx_mute,
  output reg  [3:0]  frame_delay,
  output reg         tone_gen_run,
  output reg         decoder_run,
  output reg         tone1_on,
  output reg         tone2_on,
  output reg         enc_init,
  output reg         dec_init,
  output reg  [13:0] enc_input,
  output reg         highpass_stage_bypass,
  output reg         encoded_tx_pin
);

  // ----------------------------------------------------------------
  // Pin synchroniser and register reset
  // ----------------------------------------------------------------
  reg [2:0] pdr_sync_reg;
  wire      pd_clear;

  always @(posedge clk)
  begin
    if (sys_rst)
      pdr_sync_reg <= 3'b000;
    else
      pdr_sync_reg <= {pdr_sync_reg[1:0], powerdown_reset_n};
  end

  // Held clear until two later stages agree the pin is high
  reg pd_clear_reg;
  always @(posedge clk)
  begin
    if (sys_rst)
      pd_clear_reg <= 1'b1;
    else if (pdr_sync_reg[2] == pdr_sync_reg[1])
      pd_clear_reg <= ~pdr_sync_reg[2];
  end
  assign pd_clear = sys_rst | pd_clear_reg;

  // ----------------------------------------------------------------
  // AXI4-Lite write channel
  // ----------------------------------------------------------------
  reg        aw_held_reg;
  reg [4:0]  aw_addr_reg;
  reg        w_held_reg;
  reg [31:0] w_data_reg;
  reg        w_strb0_reg;

  assign s_axi_awready = ~aw_held_reg & ~s_axi_bvalid;
  assign s_axi_wready  = ~w_held_reg & ~s_axi_bvalid;

  wire wr_fire = aw_held_reg & w_held_reg & ~s_axi_bvalid;
  wire wr_hit_low  = wr_fire & w_strb0_reg &
                     (aw_addr_reg == `TNB_OFF_TONE_LOW);
  wire wr_hit_high = wr_fire & w_strb0_reg &
                     (aw_addr_reg == `TNB_OFF_TONE_HIGH);
  wire wr_hit_ctrl = wr_fire & w_strb0_reg &
                     (aw_addr_reg == `TNB_OFF_CTRL);
  wire wr_hit_misc = wr_fire & w_strb0_reg &
                     (aw_addr_reg == `TNB_OFF_MISC);
  wire wr_mapped = (aw_addr_reg == `TNB_OFF_TONE_LOW) |
                   (aw_addr_reg == `TNB_OFF_TONE_HIGH) |
                   (aw_addr_reg == `TNB_OFF_RSVD_SIX) |
                   (aw_addr_reg == `TNB_OFF_CTRL) |
                   (aw_addr_reg == `TNB_OFF_MISC) |
                   (aw_addr_reg == `TNB_OFF_STATUS);

  always @(posedge clk)
  begin
    if (sys_rst)
    begin
      aw_held_reg  <= 1'b0;
      aw_addr_reg  <= 5'h00;
      w_held_reg   <= 1'b0;
      w_data_reg   <= 32'h0000_0000;
      w_strb0_reg  <= 1'b0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= `TNB_RESP_OKAY;
    end
    else
    begin
      if (s_axi_awvalid & s_axi_awready)
      begin
        aw_held_reg <= 1'b1;
        aw_addr_reg <= {s_axi_awaddr[4:2], 2'b00};
      end
      if (s_axi_wvalid & s_axi_wready)
      begin
        w_held_reg  <= 1'b1;
        w_data_reg  <= s_axi_wdata;
        w_strb0_reg <= s_axi_wstrb[0];
      end
      if (wr_fire)
      begin
        aw_held_reg  <= 1'b0;
        w_held_reg   <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= wr_mapped ? `TNB_RESP_OKAY : `TNB_RESP_SLVERR;
      end
      else if (s_axi_bvalid & s_axi_bready)
        s_axi_bvalid <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // Byte registers
  // ----------------------------------------------------------------
  reg [7:0] tone_param_low_reg;
  reg [7:0] tone_param_high_threshold_reg;
  reg [7:0] tone_detect_control_reg;
  reg [7:0] misc_control_reg;
  reg [7:0] ctrl_next;
  reg       noise_seen_reg;

  wire [11:0] tone_parameter = {tone_param_high_threshold_reg[
                                `TNB_PAR_HI_MSB:0],
                                tone_param_low_reg};
  wire [1:0]  tone_slot_select = tone_param_high_threshold_reg[
                                 `TNB_SLOT_MSB:`TNB_SLOT_LSB];
  wire tone_en = tone_detect_control_reg[`TNB_CTL_TONE_EN];
  wire nb_en   = tone_detect_control_reg[`TNB_CTL_NB_EN];

  always @*
  begin
    ctrl_next = tone_detect_control_reg;
    if (wr_hit_ctrl)
      ctrl_next = (w_data_reg[7:0] & `TNB_CTL_WMASK) |
                  (tone_detect_control_reg & ~`TNB_CTL_WMASK);
    // Engine consumption clears ready; a same-cycle write wins
    if (dsp_tone_read)
      ctrl_next[`TNB_CTL_READY] = 1'b0;
    if (wr_hit_high)
      ctrl_next[`TNB_CTL_READY] = 1'b1;
    // Noise while detecting beats a controller rewrite of the enable
    if (noise_detected & nb_en & ~tone_en)
      ctrl_next[`TNB_CTL_NB_EN] = 1'b0;
  end

  always @(posedge clk)
  begin
    if (pd_clear)
    begin
      tone_param_low_reg            <= `TNB_RESET_BYTE;
      tone_param_high_threshold_reg <= `TNB_RESET_BYTE;
      tone_detect_control_reg       <= `TNB_RESET_BYTE;
      misc_control_reg              <= `TNB_RESET_BYTE;
      noise_seen_reg                <= 1'b0;
    end
    else
    begin
      if (wr_hit_low)
        tone_param_low_reg <= w_data_reg[7:0];
      if (wr_hit_high)
        tone_param_high_threshold_reg <= w_data_reg[7:0];
      if (wr_hit_misc)
        misc_control_reg <= w_data_reg[7:0] & `TNB_MISC_WMASK;
      tone_detect_control_reg <= ctrl_next;
      // Mute holds until detection is re-armed
      if (noise_detected & nb_en & ~tone_en)
        noise_seen_reg <= 1'b1;
      else if (wr_hit_ctrl & w_data_reg[`TNB_CTL_NB_EN])
        noise_seen_reg <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // Engine-facing outputs
  // ----------------------------------------------------------------
  always @(posedge clk)
  begin
    if (pd_clear)
    begin
      tone1_freq            <= 12'h000;
      tone1_atten           <= 12'h000;
      tone2_freq            <= 12'h000;
      tone2_atten           <= 12'h000;
      burst_threshold       <= 8'h00;
      burst_detect_on       <= 1'b0;
      rx_mute               <= 1'b0;
      frame_delay           <= `TNB_DELAY_SHORT;
      tone_gen_run          <= 1'b0;
      decoder_run           <= 1'b1;
      tone1_on              <= 1'b0;
      tone2_on              <= 1'b0;
      enc_init              <= 1'b0;
      dec_init              <= 1'b0;
      enc_input             <= 14'h0000;
      highpass_stage_bypass <= 1'b0;
      encoded_tx_pin        <= 1'b0;
    end
    else
    begin
      if (dsp_tone_read & tone_en)
      begin
        case (tone_slot_select)
          2'b00:   tone1_freq  <= tone_parameter;
          2'b01:   tone1_atten <= tone_parameter;
          2'b10:   tone2_freq  <= tone_parameter;
          default: tone2_atten <= tone_parameter;
        endcase
      end
      burst_threshold <= (~tone_en & nb_en) ?
                         tone_param_high_threshold_reg :
                         burst_threshold;
      burst_detect_on <= nb_en & ~tone_en;
      rx_mute <= noise_seen_reg | (noise_detected & nb_en & ~tone_en);
      frame_delay <= tone_detect_control_reg[`TNB_CTL_DELAY6] ?
                     `TNB_DELAY_LONG : `TNB_DELAY_SHORT;
      tone_gen_run <= tone_en;
      decoder_run  <= ~tone_en;
      tone1_on <= tone_detect_control_reg[`TNB_CTL_TONE1];
      tone2_on <= tone_detect_control_reg[`TNB_CTL_TONE2];
      enc_init <= enc_trigger &
                  misc_control_reg[`TNB_MISC_ENC_RST];
      dec_init <= dec_trigger &
                  misc_control_reg[`TNB_MISC_DEC_RST];
      // With tone off, linear mode keeps the 8 upper bits only
      if (tone_en)
        enc_input <= tone_sample;
      else if (misc_control_reg[`TNB_MISC_LINEAR])
        enc_input <= {adc_sample[13:6], 6'b000000};
      else
        enc_input <= adc_sample;
      highpass_stage_bypass <= misc_control_reg[`TNB_MISC_HPF_DIS];
      encoded_tx_pin <= encoded_bit;
    end
  end

  // ----------------------------------------------------------------
  // AXI4-Lite read channel
  // ----------------------------------------------------------------
  assign s_axi_arready = ~s_axi_rvalid;
  wire [4:0] rd_addr = {s_axi_araddr[4:2], 2'b00};

  always @(posedge clk)
  begin
    if (sys_rst)
    begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata  <= 32'h0000_0000;
      s_axi_rresp  <= `TNB_RESP_OKAY;
    end
    else if (s_axi_arvalid & s_axi_arready)
    begin
      s_axi_rvalid <= 1'b1;
      s_axi_rresp  <= `TNB_RESP_OKAY;
      case (rd_addr)
        `TNB_OFF_TONE_LOW:  s_axi_rdata <= {24'h0, tone_param_low_reg};
        `TNB_OFF_TONE_HIGH: s_axi_rdata <= {24'h0,
                                            tone_param_high_threshold_reg};
        `TNB_OFF_RSVD_SIX:  s_axi_rdata <= 32'h0000_0000;
        `TNB_OFF_CTRL:      s_axi_rdata <= {24'h0,
                                tone_detect_control_reg & 8'hef};
        `TNB_OFF_MISC:      s_axi_rdata <= {24'h0, misc_control_reg};
        `TNB_OFF_STATUS:    s_axi_rdata <= {18'h0, enc_input};
        default:
        begin
          s_axi_rdata <= 32'h0000_0000;
          s_axi_rresp <= `TNB_RESP_SLVERR;
        end
      endcase
    end
    else if (s_axi_rready)
      s_axi_rvalid <= 1'b0;
  end

endmodule
